// [bench/host_spi_model.sv]
`timescale 1ns/1ps
// host side of the serial link: mode 0, clock stands still between frames
module host_spi_model (
    output logic      SPI_CLK,
    output logic      CS_N,
    output logic      SERIAL_IN,
    input  wire logic SERIAL_OUT
);
    // first select waits out the supply ramp, in ns
    localparam int powerup_select_delay = 20000;

    // idle bus at time zero
    initial begin
        SPI_CLK = 1'b0;
        CS_N = 1'b1;
        SERIAL_IN = 1'b0;
    end

    // opcode, address msb first
    // bits past 32 clock out the readback byte, sampled on rising edges
    task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        // no select before the power-up delay
        if ($time < powerup_select_delay) #(powerup_select_delay - $time);
        #5 CS_N = 1'b0;
        for (int i = 0; i < n; i++) begin
            SERIAL_IN = (i < 32) ? w[31-i] : ~SERIAL_IN;
            #24 SPI_CLK = 1'b1;
            if (i >= 32) rd = {rd[6:0], SERIAL_OUT};
            #24 SPI_CLK = 1'b0;
        end
        #24 CS_N = 1'b1;
        // released data line must not look like a held bit
        SERIAL_IN = ~SERIAL_IN;
        // deselect gap covers sync and effect latency
        #200;
    endtask : xfer
endmodule : host_spi_model

// [bench/serial_flash_block_lock_reset_tb.sv]
`timescale 1ns/1ps
module serial_flash_block_lock_reset_tb
    import flash_lock_pkg::*;
;
    logic        CLK_SYS, RESETN, CE, SUSPEND_SET, PARAM_LOAD;
    wp_cfg_s     WP_CFG;
    logic [23:0] CHECK_ADDR;
    logic [7:0]  READ_PARAM_IN, READ_PARAMETER_BITS;
    logic [2:0]  WRAP_IN, WRAP_SETTING_BITS;
    wire         SPI_CLK, CS_N, SERIAL_IN;
    logic        SERIAL_OUT, SERIAL_OUT_EN, WRITE_ENABLE_LATCH, SUSPEND_FLAG;
    logic        ADDR_PROTECTED, RESET_BUSY, ABORT_OP;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          n_abort = 0;
    int          n_oe = 0;

    flash_lock_core dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .SPI_CLK(SPI_CLK),
        .CS_N(CS_N), .SERIAL_IN(SERIAL_IN), .WP_CFG(WP_CFG), .CHECK_ADDR(CHECK_ADDR),
        .SUSPEND_SET(SUSPEND_SET), .PARAM_LOAD(PARAM_LOAD), .READ_PARAM_IN(READ_PARAM_IN),
        .WRAP_IN(WRAP_IN), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN),
        .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .SUSPEND_FLAG(SUSPEND_FLAG),
        .READ_PARAMETER_BITS(READ_PARAMETER_BITS), .WRAP_SETTING_BITS(WRAP_SETTING_BITS),
        .ADDR_PROTECTED(ADDR_PROTECTED), .RESET_BUSY(RESET_BUSY), .ABORT_OP(ABORT_OP));
    host_spi_model host (.SPI_CLK(SPI_CLK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN),
        .SERIAL_OUT(SERIAL_OUT));

    // 40 MHz system clock
    always #12.5 CLK_SYS = ~CLK_SYS;
    // count abort pulses, they are too short to catch inside a frame
    always @(posedge CLK_SYS) if (ABORT_OP === 1'b1) n_abort++;
    // serial clocks seen with the output driven
    always @(posedge SPI_CLK) if (SERIAL_OUT_EN === 1'b1) n_oe++;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic cmd(input logic [7:0] op, input logic [23:0] a = 24'h000000);
        logic [7:0] rd;
        host.xfer({op, a}, (op == OP_LOCK || op == OP_UNLOCK) ? 32 : 8, rd);
    endtask : cmd

    task automatic rdlock(input logic [23:0] a, input logic [7:0] exp);
        logic [7:0] rd;
        int         n0;
        n0 = n_oe;
        host.xfer({OP_READ_LOCK, a}, 40, rd);
        check(rd, exp);
        check(8'(n_oe - n0), 8'h08);
        check(SERIAL_OUT_EN, 1'b0);
    endtask : rdlock

    task automatic prot(input logic [23:0] a, input logic exp);
        @(posedge CLK_SYS) CHECK_ADDR <= a;
        repeat (3) @(posedge CLK_SYS);
        check(ADDR_PROTECTED, exp);
    endtask : prot

    task automatic t_reset_state;
        @(posedge CLK_SYS) WP_CFG.individual_protect_select <= 1'b1;
        rdlock(24'h050000, 8'h01);
        check(WRITE_ENABLE_LATCH, 1'b0);
        prot(24'h7f0000, 1'b1);
        $display("test reset_state done");
    endtask : t_reset_state

    task automatic t_unlock;
        cmd(OP_UNLOCK, 24'h050000);
        rdlock(24'h050000, 8'h01);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_UNLOCK, 24'h003000);
        rdlock(24'h003000, 8'h00);
        rdlock(24'h004000, 8'h01);
        prot(24'h003000, 1'b0);
        @(posedge CLK_SYS) WP_CFG.individual_protect_select <= 1'b0;
        prot(24'h004000, 1'b0);
        @(posedge CLK_SYS) WP_CFG.block_protect_field <= BP_ALL;
        prot(24'h003000, 1'b1);
        @(posedge CLK_SYS) WP_CFG <= '{1'b1, 1'b0, 1'b0, 1'b0, BP_NONE};
        cmd(OP_LOCK, 24'h003000);
        rdlock(24'h003000, 8'h01);
        $display("test unlock done");
    endtask : t_unlock

    task automatic t_global;
        logic [7:0] rd;
        cmd(OP_GLOBAL_UNLOCK);
        rdlock(24'h7f0000, 8'h00);
        rdlock(24'h004000, 8'h00);
        cmd(OP_GLOBAL_LOCK);
        rdlock(24'h050000, 8'h01);
        host.xfer({OP_READ_LOCK, 24'h050000}, 48, rd);
        check(rd, 8'h01);
        cmd(OP_GLOBAL_UNLOCK);
        $display("test global done");
    endtask : t_global

    task automatic t_swreset;
        int k;
        @(posedge CLK_SYS) SUSPEND_SET <= 1'b1;
        PARAM_LOAD <= 1'b1;
        READ_PARAM_IN <= 8'ha5;
        WRAP_IN <= 3'h5;
        @(posedge CLK_SYS) SUSPEND_SET <= 1'b0;
        PARAM_LOAD <= 1'b0;
        cmd(OP_RESET_ENABLE);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_RESET);
        check(8'(n_abort), 8'h00);
        check(SUSPEND_FLAG, 1'b1);
        check(READ_PARAMETER_BITS, 8'ha5);
        check(WRAP_SETTING_BITS, 3'h5);
        check(RESET_BUSY, 1'b0);
        cmd(OP_RESET_ENABLE);
        cmd(OP_RESET);
        check(8'(n_abort), 8'h01);
        check(RESET_BUSY, 1'b1);
        check(WRITE_ENABLE_LATCH, 1'b0);
        check(SUSPEND_FLAG, 1'b0);
        check(READ_PARAMETER_BITS, READ_PARAM_RESET);
        check(WRAP_SETTING_BITS, WRAP_RESET);
        cmd(OP_WRITE_ENABLE);
        for (k = 0; k < 1400 && RESET_BUSY !== 1'b0; k++) @(posedge CLK_SYS);
        if (k == 1400) begin
            n_mismatch++;
            complete_run;
        end
        check(WRITE_ENABLE_LATCH, 1'b0);
        rdlock(24'h050000, 8'h01);
        cmd(OP_WRITE_ENABLE);
        check(WRITE_ENABLE_LATCH, 1'b1);
        $display("test swreset done");
    endtask : t_swreset

    // held reset, then the scenarios in turn
    initial begin
        CLK_SYS = 1'b0;
        RESETN = 1'b0;
        CE = 1'b1;
        WP_CFG = '0;
        CHECK_ADDR = '0;
        SUSPEND_SET = 1'b0;
        PARAM_LOAD = 1'b0;
        READ_PARAM_IN = '0;
        WRAP_IN = '0;
        repeat (6) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        t_reset_state();
        t_unlock();
        t_global();
        t_swreset();
        complete_run();
    end
endmodule : serial_flash_block_lock_reset_tb

// [core/flash_lock_core.sv]
`timescale 1ns/1ps
// Summary of operation
// - per-unit lock bits decide protection only when individual select is set
// - otherwise protection comes from complement, granularity, top/bottom and range field
// - lock bits are volatile and all set after power-up or any reset
// - opcode 39h plus 24-bit address, then deselect, clears that unit's lock
// - individual unlock is ignored unless the write enable latch is set
// - opcode 36h plus address sets that unit's lock when the latch is set
// - opcode 3Dh plus address shifts the lock byte out msb first on falling edges
// - readback lsb of one means locked, zero means unlocked
// - opcode 7Eh with the latch set locks every unit
// - opcode 98h with the latch set unlocks every unit
// - accepted reset aborts work and clears latch, suspend, read and wrap settings
// - reset happens only when 66h is followed directly by 99h
// - any command after 66h other than 99h or a repeated 66h cancels the armed state
// - reset takes about 30 us and no command is taken meanwhile
module flash_lock_core
    import flash_lock_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        SPI_CLK,
    input  wire logic        CS_N,
    input  wire logic        SERIAL_IN,
    input  wire wp_cfg_s     WP_CFG,
    input  wire logic [23:0] CHECK_ADDR,
    input  wire logic        SUSPEND_SET,
    input  wire logic        PARAM_LOAD,
    input  wire logic [7:0]  READ_PARAM_IN,
    input  wire logic [2:0]  WRAP_IN,
    output logic             SERIAL_OUT,
    output logic             SERIAL_OUT_EN,
    output logic             WRITE_ENABLE_LATCH,
    output logic             SUSPEND_FLAG,
    output logic [7:0]       READ_PARAMETER_BITS,
    output logic [2:0]       WRAP_SETTING_BITS,
    output logic             ADDR_PROTECTED,
    output logic             RESET_BUSY,
    output logic             ABORT_OP
);

    typedef enum logic [1:0] {ST_READY, ST_ARMED, ST_RESETTING} rst_state_e;

    rst_state_e           state_r;
    logic [10:0]          cnt_r;
    logic                 busy_r;
    logic                 abort_r;
    logic [NUM_UNITS-1:0] lock_r;
    logic                 wel_r;
    logic                 suspend_r;
    logic [7:0]           rd_param_r;
    logic [2:0]           wrap_r;
    logic                 prot_r;
    logic                 cs_s1_r;
    logic                 cs_s2_r;
    logic                 cs_s3_r;
    frame_s               frame;
    logic                 frame_end;
    logic                 cmd_ok;
    logic                 is_short;
    logic                 is_addr;
    logic                 wr_ok;
    logic [7:0]           unit;
    logic                 do_lock;
    logic                 do_unlock;
    logic                 do_glock;
    logic                 do_gunlock;
    logic                 do_arm;
    logic                 do_reset;
    logic                 do_wren;
    logic                 do_wrdi;
    logic                 chk_lock;

    // range protection from the status configuration bits
    function automatic logic bp_protected(input wp_cfg_s c, input logic [23:0] a);
        logic [23:0] size;
        logic [2:0]  sh;
        logic        hit;
        size = '0;
        sh   = c.block_protect_field - 3'h1;
        hit  = 1'b0;
        if (c.block_protect_field == BP_ALL) begin
            size = ARRAY_BYTES;
        end else if (c.block_protect_field != BP_NONE) begin
            if (c.sector_granularity_bit) begin
                size = SECTOR_BYTES << ((sh > SEC_MAX_SHIFT) ? SEC_MAX_SHIFT : sh);
            end else begin
                size = BLOCK_PAIR_BYTES << sh;
            end
        end
        if (size != '0) begin
            hit = c.top_bottom_select ? (a < size) : (a >= ARRAY_BYTES - size);
        end
        return hit ^ c.protect_complement;
    endfunction : bp_protected

    // link side runs on the serial clock
    flash_lock_link u_link (
        .spi_clk       (SPI_CLK),
        .rst_n         (RESETN),
        .cs_n          (CS_N),
        .serial_in     (SERIAL_IN),
        .lock_vec      (lock_r),
        .frame         (frame),
        .serial_out    (SERIAL_OUT),
        .serial_out_en (SERIAL_OUT_EN)
    );

    // select synchroniser; third stage only feeds the edge detect
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else if (CE) begin
            cs_s1_r <= CS_N;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    // frame captured at the link is stable here: its clock stops with the deselect
    assign frame_end = cs_s2_r & ~cs_s3_r;
    assign cmd_ok    = CE && frame_end && !busy_r;
    assign is_short  = frame.bits == BITS_OPCODE;
    assign is_addr   = frame.bits == BITS_ADDR_CMD;
    assign wr_ok     = cmd_ok && wel_r;
    assign unit      = unit_index(frame.addr);
    // lock bit of the queried address, shared by the answer and its check
    assign chk_lock  = lock_r[unit_index(CHECK_ADDR)];

    // command decode; partial frames are dropped like an early deselect
    assign do_lock    = wr_ok && is_addr && frame.opcode == OP_LOCK;
    assign do_unlock  = wr_ok && is_addr && frame.opcode == OP_UNLOCK;
    assign do_glock   = wr_ok && is_short && frame.opcode == OP_GLOBAL_LOCK;
    assign do_gunlock = wr_ok && is_short && frame.opcode == OP_GLOBAL_UNLOCK;
    assign do_wren    = cmd_ok && is_short && frame.opcode == OP_WRITE_ENABLE;
    assign do_wrdi    = cmd_ok && is_short && frame.opcode == OP_WRITE_DISABLE;
    assign do_arm     = cmd_ok && is_short && frame.opcode == OP_RESET_ENABLE;
    // reset only straight after the enable
    assign do_reset   = cmd_ok && is_short && frame.opcode == OP_RESET
                        && state_r == ST_ARMED;

    // reset sequencer
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            state_r <= ST_READY;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end else if (CE) begin
            case (state_r)
                ST_READY: begin
                    if (do_arm) begin
                        state_r <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (do_reset) begin
                        state_r <= ST_RESETTING;
                        cnt_r   <= RST_COUNT_INIT;
                        busy_r  <= 1'b1;
                    end else if (cmd_ok && !do_arm) begin
                        state_r <= ST_READY;
                    end
                end
                ST_RESETTING: begin
                    // hold off for the recovery time
                    if (cnt_r == '0) begin
                        state_r <= ST_READY;
                        busy_r  <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 11'h001;
                    end
                end
                default: begin
                    state_r <= ST_READY;
                end
            endcase
        end
    end

    // one-cycle abort of whatever the array is doing
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            abort_r <= 1'b0;
        end else if (CE) begin
            abort_r <= do_reset;
        end
    end

    // all locked after reset
    // global commands beat single ones; they cannot coincide anyway
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            lock_r <= LOCKS_RESET;
        end else if (CE) begin
            if (do_reset) begin
                lock_r <= LOCKS_RESET;
            end else if (do_glock) begin
                lock_r <= LOCKS_RESET;
            end else if (do_gunlock) begin
                lock_r <= '0;
            end else if (do_lock) begin
                lock_r[unit] <= 1'b1;
            end else if (do_unlock) begin
                lock_r[unit] <= 1'b0;
            end
        end
    end

    // write enable latch
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            wel_r <= 1'b0;
        end else if (CE) begin
            if (do_reset || do_wrdi) begin
                wel_r <= 1'b0;
            end else if (do_wren) begin
                wel_r <= 1'b1;
            end
        end
    end

    // volatile settings back to power-on values
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            suspend_r  <= 1'b0;
            rd_param_r <= READ_PARAM_RESET;
            wrap_r     <= WRAP_RESET;
        end else if (CE) begin
            if (do_reset) begin
                suspend_r  <= 1'b0;
                rd_param_r <= READ_PARAM_RESET;
                wrap_r     <= WRAP_RESET;
            end else begin
                if (SUSPEND_SET) begin
                    suspend_r <= 1'b1;
                end
                if (PARAM_LOAD) begin
                    rd_param_r <= READ_PARAM_IN;
                    wrap_r     <= WRAP_IN;
                end
            end
        end
    end

    // protection answer for the array, one cycle behind the address
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            prot_r <= 1'b1;
        end else if (CE) begin
            if (WP_CFG.individual_protect_select) begin
                prot_r <= chk_lock;
            end else begin
                prot_r <= bp_protected(WP_CFG, CHECK_ADDR);
            end
        end
    end

    assign WRITE_ENABLE_LATCH  = wel_r;
    assign SUSPEND_FLAG        = suspend_r;
    assign READ_PARAMETER_BITS = rd_param_r;
    assign WRAP_SETTING_BITS   = wrap_r;
    assign ADDR_PROTECTED      = prot_r;
    assign RESET_BUSY          = busy_r;
    assign ABORT_OP            = abort_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_armed_then_reset;
        state_r == ST_ARMED ##0 CE && frame_end && !busy_r && is_short
            && frame.opcode == OP_RESET;
    endsequence

    sequence s_reset_done;
        busy_r && !wel_r && !suspend_r && rd_param_r == READ_PARAM_RESET
            && wrap_r == WRAP_RESET && lock_r == LOCKS_RESET;
    endsequence

    property p_lock_reset;
        $rose(RESETN) |-> lock_r == LOCKS_RESET;
    endproperty
    a_lock_reset: assert property (p_lock_reset) else $error("locks not set after reset");

    property p_unlock_gated;
        CE && frame_end && frame.opcode == OP_UNLOCK && !wel_r |=> $stable(lock_r);
    endproperty
    a_unlock_gated: assert property (p_unlock_gated) else $error("unlock without latch");

    property p_unlock_one;
        CE && frame_end && !busy_r && wel_r && is_addr && frame.opcode == OP_UNLOCK
            |=> !lock_r[$past(unit)];
    endproperty
    a_unlock_one: assert property (p_unlock_one) else $error("unit not unlocked");

    property p_lock_one;
        CE && frame_end && !busy_r && wel_r && is_addr && frame.opcode == OP_LOCK
            |=> lock_r[$past(unit)];
    endproperty
    a_lock_one: assert property (p_lock_one) else $error("unit not locked");

    property p_global_lock;
        CE && frame_end && !busy_r && wel_r && is_short
            && frame.opcode == OP_GLOBAL_LOCK |=> lock_r == LOCKS_RESET;
    endproperty
    a_global_lock: assert property (p_global_lock) else $error("global lock failed");

    property p_global_unlock;
        CE && frame_end && !busy_r && wel_r && is_short
            && frame.opcode == OP_GLOBAL_UNLOCK |=> lock_r == '0;
    endproperty
    a_global_unlock: assert property (p_global_unlock) else $error("global unlock failed");

    property p_reset_clears;
        s_armed_then_reset |=> s_reset_done ##1 busy_r;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

    property p_reset_needs_arm;
        $rose(busy_r) |-> $past(state_r) == ST_ARMED;
    endproperty
    a_reset_needs_arm: assert property (p_reset_needs_arm) else $error("reset not armed");

    property p_disarm;
        state_r == ST_ARMED && cmd_ok && frame.opcode != OP_RESET
            && frame.opcode != OP_RESET_ENABLE |=> state_r == ST_READY;
    endproperty
    a_disarm: assert property (p_disarm) else $error("arm not cancelled");

    property p_reset_time;
        $rose(busy_r) |-> cnt_r == RST_COUNT_INIT ##1 busy_r[*8];
    endproperty
    a_reset_time: assert property (p_reset_time) else $error("reset time wrong");

    property p_busy_ignores;
        busy_r && CE && frame_end |=> $stable(lock_r) && $stable(wel_r);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("command taken in reset");

    property p_individual;
        CE && WP_CFG.individual_protect_select
            |=> prot_r == $past(chk_lock);
    endproperty
    a_individual: assert property (p_individual) else $error("wrong lock source");

endmodule : flash_lock_core

// [core/flash_lock_link.sv]
`timescale 1ns/1ps
module flash_lock_link
    import flash_lock_pkg::*;
(
    input  wire logic                 spi_clk,
    input  wire logic                 rst_n,
    input  wire logic                 cs_n,
    input  wire logic                 serial_in,
    input  wire logic [NUM_UNITS-1:0] lock_vec,
    output frame_s                    frame,
    output logic                      serial_out,
    output logic                      serial_out_en
);

    logic                 started_r;
    frame_s               frm_r;
    logic [2:0]           out_idx_r;
    logic [NUM_UNITS-1:0] lock_s1_r;
    logic [NUM_UNITS-1:0] lock_s2_r;

    assign frame = frm_r;

    // first edge of a frame restarts the capture; deselect clears it at once
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // shift in on rising edge
    // frame stays put after deselect, the clock is idle until the next one
    always_ff @(posedge spi_clk or negedge rst_n) begin
        if (!rst_n) begin
            frm_r <= '0;
        end else if (!started_r) begin
            frm_r.opcode <= {7'h00, serial_in};
            frm_r.addr   <= '0;
            frm_r.bits   <= BITS_FIRST;
        end else begin
            if (frm_r.bits < BITS_OPCODE) begin
                frm_r.opcode <= {frm_r.opcode[6:0], serial_in};
            end else if (frm_r.bits < BITS_ADDR_CMD) begin
                frm_r.addr <= {frm_r.addr[22:0], serial_in};
            end
            if (frm_r.bits != BITS_MAX) begin
                frm_r.bits <= frm_r.bits + 6'h01;
            end
        end
    end

    // byte slot counter, wraps so the byte repeats
    always_ff @(posedge spi_clk) begin
        if (!started_r) begin
            out_idx_r <= '0;
        end else if (frm_r.bits >= BITS_ADDR_CMD) begin
            out_idx_r <= out_idx_r + 3'h1;
        end
    end

    // lock bits only change between frames, so each bit is a level synchronised alone
    always_ff @(posedge spi_clk) begin
        lock_s1_r <= lock_vec;
        lock_s2_r <= lock_s1_r;
    end

    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (started_r && frm_r.opcode == OP_READ_LOCK
                     && frm_r.bits >= BITS_ADDR_CMD) begin
            serial_out_en <= 1'b1;
            serial_out    <= (out_idx_r == LSB_SLOT) ? lock_s2_r[unit_index(frm_r.addr)] : 1'b0;
        end
    end

endmodule : flash_lock_link

// [shared/flash_lock_pkg.sv]
package flash_lock_pkg;

    // opcodes shifted in on the serial input, msb first
    localparam logic [7:0] OP_LOCK          = 8'h36;
    localparam logic [7:0] OP_UNLOCK        = 8'h39;
    localparam logic [7:0] OP_READ_LOCK     = 8'h3d;
    localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7e;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RESET         = 8'h99;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

    // frame lengths in serial clock edges
    localparam logic [5:0] BITS_OPCODE   = 6'h08;
    localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
    localparam logic [5:0] BITS_MAX      = 6'h3f;
    localparam logic [5:0] BITS_FIRST    = 6'h01;

    // protection units: 16 sectors in the first and last block, whole blocks between
    localparam int         NUM_UNITS       = 158;
    localparam logic [6:0] FIRST_BLOCK     = 7'h00;
    localparam logic [6:0] LAST_BLOCK      = 7'h7f;
    localparam logic [3:0] TOP_SECTOR_BASE = 4'h1;
    localparam logic [7:0] BLOCK_UNIT_BASE = 8'h1f;
    localparam logic [NUM_UNITS-1:0] LOCKS_RESET = {NUM_UNITS{1'b1}};

    // range protection geometry
    localparam logic [23:0] ARRAY_BYTES      = 24'h800000;
    localparam logic [23:0] SECTOR_BYTES     = 24'h001000;
    localparam logic [23:0] BLOCK_PAIR_BYTES = 24'h020000;
    localparam logic [2:0]  BP_NONE          = 3'h0;
    localparam logic [2:0]  BP_ALL           = 3'h7;
    localparam logic [2:0]  SEC_MAX_SHIFT    = 3'h3;

    // readback byte: lock value sits in the last bit shifted out
    localparam logic [2:0] LSB_SLOT = 3'h7;

    // software reset recovery time
    localparam int          RESET_TIME_NS   = 30000;
    localparam int          SYS_PERIOD_NS   = 25;
    localparam int          RESET_CYCLES    = (RESET_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [10:0] RST_COUNT_INIT  = 11'(RESET_CYCLES - 1);

    // reset values of the volatile settings
    localparam logic [7:0] READ_PARAM_RESET = 8'h00;
    localparam logic [2:0] WRAP_RESET       = 3'h0;

    // command frame as captured at the link
    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [5:0]  bits;
    } frame_s;

    // range protection configuration bits
    typedef struct packed {
        logic       individual_protect_select;
        logic       protect_complement;
        logic       sector_granularity_bit;
        logic       top_bottom_select;
        logic [2:0] block_protect_field;
    } wp_cfg_s;

    // map a byte address onto its protection unit
    function automatic logic [7:0] unit_index(input logic [23:0] a);
        logic [6:0] blk;
        blk = a[22:16];
        if (blk == FIRST_BLOCK) begin
            return {4'h0, a[15:12]};
        end else if (blk == LAST_BLOCK) begin
            return {TOP_SECTOR_BASE, a[15:12]};
        end else begin
            return 8'(blk) + BLOCK_UNIT_BASE;
        end
    endfunction : unit_index

endpackage : flash_lock_pkg
